// [include/gcd_pkg.sv]
/*
 * Shared constants, field layouts and carrier types for the ground command
 * word decoder.
 * Assumes a single 20 MHz clock and a receiver that marks each bit.
 */
package gcd_pkg;

	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_BITS = 26;
	localparam int FRAME_BITS = 3;
	localparam int CMD_ADDR_BITS = 5;
	localparam int FIELD_BITS = 18;
	localparam int REG_ADDR_BITS = 5;
	localparam int TIME_BITS = 11;
	localparam int BODY_BITS = WORD_BITS - FRAME_BITS;
	localparam int BODY_CNT_W = 5;
	localparam logic [BODY_CNT_W-1:0] BODY_LAST = BODY_CNT_W'(BODY_BITS - 1);
	localparam int FILL_W = 2;
	localparam logic [FILL_W-1:0] FILL_READY = FILL_W'(FRAME_BITS - 1);

	// Start pattern, arbitrary value of our own
	localparam logic [FRAME_BITS-1:0] FRAME_PATTERN = 3'h6;
	// Command address shared by every quantitative command
	localparam logic [CMD_ADDR_BITS-1:0] QUANT_CMD_ADDR = 5'h1F;
	// Sequencer register addresses
	localparam logic [REG_ADDR_BITS-1:0] REG_PITCH = 5'h01;
	localparam logic [REG_ADDR_BITS-1:0] REG_ROLL = 5'h02;
	localparam logic [REG_ADDR_BITS-1:0] REG_BURN = 5'h03;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int BIT_PERIOD_MS = 1000;
	// A missing bit is declared after one and a half bit periods
	localparam int BIT_TIMEOUT_MS = 1500;
	localparam int BIT_TIMEOUT_CYC = (CLK_HZ / 1000) * BIT_TIMEOUT_MS;
	localparam int TMR_W = 25;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [REG_ADDR_BITS-1:0] reg_addr;
		logic parity;
		logic [TIME_BITS-1:0] time_code;
		logic positive;
	} gcd_field_type;

	typedef struct packed {
		logic [TIME_BITS-1:0] time_code;
		logic positive;
	} gcd_dur_type;

	localparam gcd_dur_type DUR_RESET = '0;
	localparam logic [TIME_BITS-1:0] TIME_RESET = '0;

	typedef enum logic [1:0] {
		ST_HUNT,
		ST_BODY,
		ST_DECODE
	} gcd_state_type;

	// True when the whole sequencer field holds an odd count of ones
	function automatic logic gcd_odd_parity(input gcd_field_type f);
		return ^f;
	endfunction : gcd_odd_parity

endpackage : gcd_pkg

// [rtl/gcd_bit_timer.sv]
/*
 * Bit gap watchdog: counts clock cycles since the last bit strobe while
 * armed and raises a timeout when the gap grows too long.
 * Assumes strobes are one-cycle pulses synchronous to CLK.
 */
`timescale 1ns/10ps
module gcd_bit_timer import gcd_pkg::*; #(
	parameter int unsigned LIMIT = BIT_TIMEOUT_CYC
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic arm, // Watch the gap while high
	input wire logic strobe, // A bit arrived
	output logic timeout // Gap exceeded while armed
);

	localparam logic [TMR_W-1:0] LIMIT_M1 = TMR_W'(LIMIT - 1);

	logic [TMR_W-1:0] gap_cnt;

	// ---------------------------------------------------------------
	// Gap counter
	// ---------------------------------------------------------------
	// Saturates so the timeout stays up until the owner disarms or a strobe arrives
	always_ff @(posedge clk) begin
		if (!rst_n || !arm || strobe) begin
			gap_cnt <= '0;
		end else if (gap_cnt != LIMIT_M1) begin
			gap_cnt <= gap_cnt + 1'b1;
		end
	end

	assign timeout = arm && !strobe && (gap_cnt == LIMIT_M1);

endmodule : gcd_bit_timer

// [rtl/gcd_decoder.sv]
/*
 * Ground command word decoder: aligns on the start bits of a serial
 * command word, collects the address and sequencer field, fires direct
 * commands and loads quantitative commands into the sequencer registers.
 * Assumes the bit receiver gives one data bit with a one-cycle strobe per
 * bit, first bit first, both synchronous to CLK.
 */
`timescale 1ns/10ps

module gcd_decoder import gcd_pkg::*; #(
	parameter int unsigned BIT_TIMEOUT = BIT_TIMEOUT_CYC
) (
	input wire logic CLK, // System clock, 20 MHz
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic CMD_BIT, // Serial command data
	input wire logic CMD_BIT_STROBE, // One-cycle pulse per received bit
	output logic DIRECT_PULSE, // Direct command fired
	output logic [CMD_ADDR_BITS-1:0] DIRECT_ADDR, // Address of last direct command
	output logic QUANT_LOADED, // Sequencer register loaded
	output logic PARITY_ERR, // Quantitative field failed odd parity
	output logic TIMEOUT_ERR, // Word abandoned on a missing bit
	output logic WORD_BUSY, // Collecting a word
	output gcd_dur_type PITCH_DUR, // Pitch turn duration
	output gcd_dur_type ROLL_DUR, // Roll turn duration
	output logic [TIME_BITS-1:0] BURN_TIME // Motor burn time code
);

	gcd_state_type state;
	logic [FRAME_BITS-1:0] hunt_window;
	logic [FRAME_BITS-1:0] next_window;
	logic [FILL_W-1:0] hunt_fill;
	logic [BODY_BITS-1:0] body_sr;
	logic [BODY_CNT_W-1:0] body_cnt;
	logic [CMD_ADDR_BITS-1:0] cmd_addr;
	gcd_field_type field;
	logic frame_hit;
	logic last_bit;
	logic decode;
	logic is_quant;
	logic bit_timeout;

	// ---------------------------------------------------------------
	// Word slicing
	// ---------------------------------------------------------------
	// First received bit ends up at the top of the shift register
	assign cmd_addr = body_sr[BODY_BITS-1 -: CMD_ADDR_BITS];
	assign field = gcd_field_type'(body_sr[FIELD_BITS-1:0]);
	assign next_window = {hunt_window[FRAME_BITS-2:0], CMD_BIT};
	assign frame_hit = CMD_BIT_STROBE && hunt_fill == FILL_READY
		&& next_window == FRAME_PATTERN;
	assign last_bit = CMD_BIT_STROBE && body_cnt == BODY_LAST;
	assign decode = state == ST_DECODE;
	assign is_quant = cmd_addr == QUANT_CMD_ADDR;
	assign WORD_BUSY = state != ST_HUNT;

	// ---------------------------------------------------------------
	// Bit gap watch
	// ---------------------------------------------------------------
	// Bits are a second apart, so a long gap means the word was lost
	gcd_bit_timer #(
		.LIMIT(BIT_TIMEOUT)
	) u_timer (
		.clk(CLK),
		.rst_n(RST_N),
		.arm(state == ST_BODY),
		.strobe(CMD_BIT_STROBE),
		.timeout(bit_timeout)
	);

	// ---------------------------------------------------------------
	// Sequence control
	// ---------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state <= ST_HUNT;
		end else begin
			unique case (state)
				ST_HUNT: begin
					if (frame_hit) begin
						state <= ST_BODY;
					end
				end
				ST_BODY: begin
					if (bit_timeout) begin
						state <= ST_HUNT;
					end else if (last_bit) begin
						state <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					state <= ST_HUNT;
				end
				default: begin
					state <= ST_HUNT;
				end
			endcase
		end
	end

	// Start bits are searched on a sliding window, so a false start
	// costs at most one word and realigns on the next one
	always_ff @(posedge CLK) begin
		if (!RST_N || state != ST_HUNT) begin
			hunt_window <= '0;
			hunt_fill <= '0;
		end else if (CMD_BIT_STROBE) begin
			hunt_window <= next_window;
			if (hunt_fill != FILL_READY) begin
				hunt_fill <= hunt_fill + 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			body_sr <= '0;
			body_cnt <= '0;
		end else if (state == ST_HUNT) begin
			body_cnt <= '0;
		end else if (state == ST_BODY && CMD_BIT_STROBE) begin
			body_sr <= {body_sr[BODY_BITS-2:0], CMD_BIT};
			body_cnt <= body_cnt + 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Direct commands and timeout error
	// ---------------------------------------------------------------
	// The field is ignored here; the sender keeps it all zero
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIRECT_PULSE <= 1'b0;
		end else begin
			DIRECT_PULSE <= decode && !is_quant;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIRECT_ADDR <= '0;
		end else if (decode && !is_quant) begin
			DIRECT_ADDR <= cmd_addr;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			TIMEOUT_ERR <= 1'b0;
		end else begin
			TIMEOUT_ERR <= state == ST_BODY && bit_timeout;
		end
	end

	// ---------------------------------------------------------------
	// Quantitative commands
	// ---------------------------------------------------------------
	// Registers hold 11-bit codes, enough for 1319 s and 102.36 s scales
	gcd_seq_regs u_regs (
		.clk(CLK),
		.rst_n(RST_N),
		.load(decode && is_quant),
		.field(field),
		.pitch(PITCH_DUR),
		.roll(ROLL_DUR),
		.burn(BURN_TIME),
		.loaded(QUANT_LOADED),
		.parity_err(PARITY_ERR)
	);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	a_word_length: assert property (
		state == ST_DECODE |-> $past(body_cnt) == BODY_LAST && $past(CMD_BIT_STROBE)
	) else $error("word decoded with wrong bit count");

	a_frame_align: assert property (
		state == ST_BODY && $past(state) == ST_HUNT |-> $past(next_window) == FRAME_PATTERN
	) else $error("body entered without start bits");

	a_reg_address: assert property (
		decode && is_quant && gcd_odd_parity(field) && field.reg_addr == REG_PITCH
		|=> QUANT_LOADED && PITCH_DUR.time_code == $past(field.time_code)
	) else $error("pitch register not loaded from field");

	a_roll_sense: assert property (
		decode && is_quant && gcd_odd_parity(field) && field.reg_addr == REG_ROLL
		|=> ROLL_DUR.positive == $past(field.positive) && ROLL_DUR.time_code == $past(field.time_code)
	) else $error("roll sense or value wrong");

	a_direct_now: assert property (
		decode && !is_quant |=> DIRECT_PULSE && DIRECT_ADDR == $past(cmd_addr)
		&& PITCH_DUR == $past(PITCH_DUR) && !QUANT_LOADED ##1 !DIRECT_PULSE
	) else $error("direct command not fired alone");

	a_quant_no_direct: assert property (
		decode && is_quant |=> !DIRECT_PULSE
	) else $error("quantitative command fired a direct pulse");

	a_regs_hold: assert property (
		PITCH_DUR != $past(PITCH_DUR) || ROLL_DUR != $past(ROLL_DUR) || BURN_TIME != $past(BURN_TIME)
		|-> QUANT_LOADED
	) else $error("register changed without a load");

	a_bit_gap: assert property (
		state == ST_BODY && bit_timeout |=> state == ST_HUNT && TIMEOUT_ERR
	) else $error("missing bit did not abandon word");

	a_parity_reject: assert property (
		decode && is_quant && !gcd_odd_parity(field)
		|=> PARITY_ERR && !QUANT_LOADED && PITCH_DUR == $past(PITCH_DUR) && ROLL_DUR == $past(ROLL_DUR)
	) else $error("bad parity field was accepted");

	a_burn_load: assert property (
		decode && is_quant && gcd_odd_parity(field) && field.reg_addr == REG_BURN
		|=> QUANT_LOADED && BURN_TIME == $past(field.time_code)
	) else $error("burn register not loaded from field");

	a_pitch_sense: assert property (
		decode && is_quant && gcd_odd_parity(field) && field.reg_addr == REG_PITCH
		|=> PITCH_DUR.positive == $past(field.positive)
	) else $error("pitch sense wrong");

	// A load must touch only the register that the field addresses
	a_pitch_only: assert property (
		decode && is_quant && field.reg_addr == REG_PITCH
		|=> ROLL_DUR == $past(ROLL_DUR) && BURN_TIME == $past(BURN_TIME)
	) else $error("pitch load disturbed another register");

	a_roll_only: assert property (
		decode && is_quant && field.reg_addr == REG_ROLL
		|=> PITCH_DUR == $past(PITCH_DUR) && BURN_TIME == $past(BURN_TIME)
	) else $error("roll load disturbed another register");

	a_burn_only: assert property (
		decode && is_quant && field.reg_addr == REG_BURN
		|=> PITCH_DUR == $past(PITCH_DUR) && ROLL_DUR == $past(ROLL_DUR)
	) else $error("burn load disturbed another register");

	// Unknown register addresses are dropped without a load pulse
	a_unknown_reg: assert property (
		decode && is_quant && field.reg_addr != REG_PITCH && field.reg_addr != REG_ROLL
		&& field.reg_addr != REG_BURN
		|=> !QUANT_LOADED && PITCH_DUR == $past(PITCH_DUR) && ROLL_DUR == $past(ROLL_DUR)
		&& BURN_TIME == $past(BURN_TIME)
	) else $error("unknown register address stored a value");

	// Consumers count pulses, so each must stand exactly one cycle
	a_direct_single: assert property (
		DIRECT_PULSE |=> !DIRECT_PULSE
	) else $error("direct pulse stood too long");

	a_load_single: assert property (
		QUANT_LOADED |=> !QUANT_LOADED
	) else $error("load pulse stood too long");

	a_parity_only_quant: assert property (
		PARITY_ERR |-> $past(decode) && $past(is_quant)
	) else $error("parity error without a quantitative word");

	a_addr_hold: assert property (
		DIRECT_ADDR != $past(DIRECT_ADDR) |-> DIRECT_PULSE
	) else $error("direct address changed without a command");

	a_busy_start: assert property (
		$rose(WORD_BUSY) |-> $past(CMD_BIT_STROBE) && $past(next_window) == FRAME_PATTERN
	) else $error("word started without start bits");

	a_busy_end: assert property (
		$fell(WORD_BUSY) |-> $past(state) == ST_DECODE || $past(bit_timeout)
	) else $error("word ended without decode or timeout");

	a_decode_once: assert property (
		decode |=> state == ST_HUNT
	) else $error("decode lasted more than one cycle");

	a_timeout_pulse: assert property (
		TIMEOUT_ERR |-> state == ST_HUNT ##1 !TIMEOUT_ERR
	) else $error("timeout did not return to hunting once");

	c_direct: cover property (decode && !is_quant ##1 DIRECT_PULSE);
	c_burn_load: cover property (decode && is_quant && field.reg_addr == REG_BURN ##1 QUANT_LOADED);
	c_pitch_load: cover property (QUANT_LOADED && PITCH_DUR.positive);
	c_parity_err: cover property (PARITY_ERR);
	c_timeout: cover property (TIMEOUT_ERR);

endmodule : gcd_decoder

// [rtl/gcd_seq_regs.sv]
/*
 * Sequencer duration registers loaded by quantitative commands.
 * Assumes load is a one-cycle pulse with the field stable in that cycle.
 */
`timescale 1ns/10ps
module gcd_seq_regs import gcd_pkg::*; (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic load, // Quantitative command decoded
	input wire gcd_field_type field, // Sequencer field of the word
	output gcd_dur_type pitch, // Pitch turn duration and sense
	output gcd_dur_type roll, // Roll turn duration and sense
	output logic [TIME_BITS-1:0] burn, // Motor burn time code
	output logic loaded, // A register took a value
	output logic parity_err // Field failed odd parity
);

	logic good;

	assign good = load && gcd_odd_parity(field);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Codes are kept as received; the pseudo-binary scale is the consumer's
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pitch <= DUR_RESET;
		end else if (good && field.reg_addr == REG_PITCH) begin
			pitch <= '{time_code: field.time_code, positive: field.positive};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			roll <= DUR_RESET;
		end else if (good && field.reg_addr == REG_ROLL) begin
			roll <= '{time_code: field.time_code, positive: field.positive};
		end
	end

	// Burn sense is always positive from the sender, so it is not kept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			burn <= TIME_RESET;
		end else if (good && field.reg_addr == REG_BURN) begin
			burn <= field.time_code;
		end
	end

	// ---------------------------------------------------------------
	// Status pulses
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loaded <= 1'b0;
			parity_err <= 1'b0;
		end else begin
			loaded <= good && (field.reg_addr == REG_PITCH || field.reg_addr == REG_ROLL
				|| field.reg_addr == REG_BURN);
			parity_err <= load && !gcd_odd_parity(field);
		end
	end

endmodule : gcd_seq_regs

// [test/gcd_decoder_test.sv]
/*
 * Self-checking bench for the command word decoder: words from the
 * transmitter model, pulses counted by a monitor, registers compared.
 * Assumes a shortened bit gap limit of 40 cycles.
 */
`timescale 1ns/10ps
module gcd_decoder_test import gcd_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic send = 1'b0;
	logic [WORD_BITS-1:0] word = '0;
	logic [4:0] nbits = '0;
	logic [7:0] gap = '0;
	logic cmd_bit, cmd_strobe, tx_busy;
	logic direct_pulse, quant_loaded, parity_err, timeout_err, word_busy;
	logic [CMD_ADDR_BITS-1:0] direct_addr;
	gcd_dur_type pitch_dur, roll_dur, exp_pitch, exp_roll;
	logic [TIME_BITS-1:0] burn_time, exp_burn;
	int err_count = 0;
	int comparisons = 0;
	int n_dir = 0, n_q = 0, n_par = 0, n_tmo = 0;

	always #25 clk = ~clk;

	gcd_transmitter gcd_transmitter_i (.clk(clk), .rst_n(rst_n), .send(send), .word(word), .nbits(nbits),
		.gap(gap), .cmd_bit(cmd_bit), .cmd_strobe(cmd_strobe), .busy(tx_busy));

	gcd_decoder #(.BIT_TIMEOUT(40)) gcd_decoder_i (.CLK(clk), .RST_N(rst_n), .CMD_BIT(cmd_bit),
		.CMD_BIT_STROBE(cmd_strobe), .DIRECT_PULSE(direct_pulse), .DIRECT_ADDR(direct_addr),
		.QUANT_LOADED(quant_loaded), .PARITY_ERR(parity_err), .TIMEOUT_ERR(timeout_err),
		.WORD_BUSY(word_busy), .PITCH_DUR(pitch_dur), .ROLL_DUR(roll_dur), .BURN_TIME(burn_time));

	// Pulses are counted, so a pulse that stands two cycles shows as two
	always @(posedge clk) begin
		if (direct_pulse === 1'b1) n_dir++;
		if (quant_loaded === 1'b1) n_q++;
		if (parity_err === 1'b1) n_par++;
		if (timeout_err === 1'b1) n_tmo++;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, expected, seen);
		end
	endtask : check

	function automatic logic [WORD_BITS-1:0] quant_word(logic [4:0] r, logic [10:0] t, logic p);
		return {FRAME_PATTERN, QUANT_CMD_ADDR, r, ~^{r, t, p}, t, p};
	endfunction : quant_word

	// Sends a word, then checks the pulse counts and all duration registers
	task automatic send_word(input logic [WORD_BITS-1:0] w, input logic [4:0] n, input logic [7:0] g,
		input int e_dir, input int e_q, input int e_par, input int e_tmo);
		int d0, q0, p0, t0, i;
		d0 = n_dir;
		q0 = n_q;
		p0 = n_par;
		t0 = n_tmo;
		word <= w;
		nbits <= n;
		gap <= g;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 8000 && tx_busy !== 1'b0; i++)
			@(posedge clk);
		if (i == 8000) begin
			err_count++;
			close_out();
		end
		// One cycle after the last bit the decoder is still busy if it aligned
		check("busy at end", 32'(word_busy), 32'(w[WORD_BITS-1 -: FRAME_BITS] == FRAME_PATTERN));
		repeat (60) @(posedge clk);
		check("direct pulses", 32'(n_dir - d0), 32'(e_dir));
		check("quant loads", 32'(n_q - q0), 32'(e_q));
		check("parity errors", 32'(n_par - p0), 32'(e_par));
		check("timeouts", 32'(n_tmo - t0), 32'(e_tmo));
		check("pitch", 32'(pitch_dur), 32'(exp_pitch));
		check("roll", 32'(roll_dur), 32'(exp_roll));
		check("burn", 32'(burn_time), 32'(exp_burn));
		check("busy idle", 32'(word_busy), 32'h0);
	endtask : send_word

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic quant_loads();
		exp_pitch = gcd_dur_type'({11'h527, 1'b1});
		send_word(quant_word(REG_PITCH, 11'h527, 1'b1), 5'h1A, 8'h02, 0, 1, 0, 0);
		exp_roll = gcd_dur_type'({11'h001, 1'b0});
		send_word(quant_word(REG_ROLL, 11'h001, 1'b0), 5'h1A, 8'h1E, 0, 1, 0, 0);
		exp_burn = 11'h7FF;
		send_word(quant_word(REG_BURN, 11'h7FF, 1'b1), 5'h1A, 8'h00, 0, 1, 0, 0);
		exp_pitch = gcd_dur_type'({11'h2AA, 1'b0});
		send_word(quant_word(REG_PITCH, 11'h2AA, 1'b0), 5'h1A, 8'h05, 0, 1, 0, 0);
	endtask : quant_loads

	task automatic parity_refused();
		logic [WORD_BITS-1:0] w;
		w = quant_word(REG_ROLL, 11'h155, 1'b1);
		w[12] = ~w[12];
		send_word(w, 5'h1A, 8'h03, 0, 0, 1, 0);
		send_word(quant_word(5'h04, 11'h0F0, 1'b1), 5'h1A, 8'h03, 0, 0, 0, 0);
	endtask : parity_refused

	task automatic direct_cmds();
		send_word({FRAME_PATTERN, 5'h0A, 18'h00000}, 5'h1A, 8'h03, 1, 0, 0, 0);
		check("direct addr", 32'(direct_addr), 32'h0A);
		send_word({FRAME_PATTERN, 5'h1E, 18'h00000}, 5'h1A, 8'h03, 1, 0, 0, 0);
		check("direct addr", 32'(direct_addr), 32'h1E);
	endtask : direct_cmds

	task automatic bad_frame();
		send_word({3'h2, 5'h00, 18'h00000}, 5'h1A, 8'h02, 0, 0, 0, 0);
		check("direct addr kept", 32'(direct_addr), 32'h1E);
	endtask : bad_frame

	task automatic broken_word();
		send_word(quant_word(REG_BURN, 11'h123, 1'b1), 5'h0A, 8'h03, 0, 0, 0, 1);
		exp_burn = 11'h321;
		send_word(quant_word(REG_BURN, 11'h321, 1'b1), 5'h1A, 8'h03, 0, 1, 0, 0);
	endtask : broken_word

	initial begin
		exp_pitch = DUR_RESET;
		exp_roll = DUR_RESET;
		exp_burn = TIME_RESET;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check("reset pitch", 32'(pitch_dur), 32'h0);
		quant_loads();
		parity_refused();
		direct_cmds();
		bad_frame();
		broken_word();
		close_out();
	end
endmodule : gcd_decoder_test

// [test/gcd_transmitter.sv]
/*
 * Ground transmitter model: shifts a command word out first bit first, one
 * strobe per bit, with a chosen idle gap; may stop early to break a word.
 * Assumes the bench raises send for one cycle while the model is idle.
 */
`timescale 1ns/10ps
module gcd_transmitter import gcd_pkg::*; (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic send, // Start a word
	input wire logic [WORD_BITS-1:0] word, // Word, first bit in the MSB
	input wire logic [4:0] nbits, // Bits to send; fewer abandons the word
	input wire logic [7:0] gap, // Idle cycles between bits
	output logic cmd_bit, // Serial data
	output logic cmd_strobe, // One pulse per bit
	output logic busy // Word in progress
);
	logic [WORD_BITS-1:0] shift;
	logic [4:0] left;
	logic [7:0] wait_cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cmd_strobe <= 1'b0;
			cmd_bit <= 1'b0;
			left <= '0;
			wait_cnt <= '0;
			shift <= '0;
		end else begin
			cmd_strobe <= 1'b0;
			// Data is not held past its strobe, so a late sample sees garbage
			if (cmd_strobe)
				cmd_bit <= ~cmd_bit;
			if (send && !busy) begin
				shift <= word;
				left <= nbits;
				wait_cnt <= gap;
				busy <= 1'b1;
			end else if (busy) begin
				if (left == 5'h00)
					busy <= 1'b0;
				else if (wait_cnt != 8'h00)
					wait_cnt <= wait_cnt - 8'h01;
				else begin
					cmd_bit <= shift[WORD_BITS-1];
					cmd_strobe <= 1'b1;
					shift <= shift << 1;
					left <= left - 5'h01;
					wait_cnt <= gap;
				end
			end
		end
	end
endmodule : gcd_transmitter
